// [hw/bfc_branch_unit.v]
// Branch flow control unit: executes one branch-group instruction
// loaded over APB, using external memory for the return-address stack.
// Assumes memory returns read data in the cycle after the read strobe
// and accepts a write in the cycle its strobe is high.
//
// How it works
// - branch instructions never alter any condition flag
// - conditional branches test one selected processor flag
// - condition field picks zero/carry/parity/sign and polarity
// - jump loads PC from byte3 high, byte2 low
// - conditional jump loads target only when condition holds
// - call pushes next address, drops stack two, jumps
// - conditional call performs call only when condition holds
// - restart pushes next address, stack pointer minus two
// - restart sets PC to eight times vector
// - return pops low then high, stack rises two
// - conditional return pops only when condition holds
// - HL jump copies H high, L low into PC
`timescale 1ns/1ps
`include "bfc_regs.vh"

module bfc_branch_unit (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Stack memory port
	output reg  [15:0] mem_addr,
	output reg  [7:0]  mem_wdata,
	output reg         mem_wr,
	output reg         mem_rd,
	input  wire [7:0]  mem_rdata,
	// Execution state
	output reg         exec_busy
);

	// ****************************************************************
	// State encoding
	// ****************************************************************
	// Two push states and three pop states; idle waits for a start
	localparam [2:0] S_IDLE   = 3'd0;
	localparam [2:0] S_EXEC   = 3'd1;
	localparam [2:0] S_PUSH_A = 3'd2;
	localparam [2:0] S_PUSH_B = 3'd3;
	localparam [2:0] S_POP_A  = 3'd4;
	localparam [2:0] S_POP_B  = 3'd5;
	localparam [2:0] S_POP_C  = 3'd6;
	// Code 3'd7 is unused and falls back to idle

	// ****************************************************************
	// Storage
	// ****************************************************************
	// Sequencer state and software-loaded operands
	reg  [2:0]  state_r;
	reg  [23:0] instr_r;
	reg  [15:0] program_counter_r;
	reg  [15:0] stack_pointer_r;
	reg  [15:0] hl_r;
	reg  [7:0]  flags_r;
	// Addresses held across the stack states
	reg  [15:0] target_r;
	reg  [15:0] return_addr_r;
	reg  [7:0]  pop_low_r;
	// Status word fields
	reg         done_r;
	reg         taken_r;
	reg         illegal_r;
	reg  [3:0]  cycles_r;
	reg  [4:0]  states_r;

	// ****************************************************************
	// Decode and condition
	// ****************************************************************
	wire [7:0]  opcode = instr_r[7:0];
	wire [15:0] addr_bytes = {instr_r[23:16], instr_r[15:8]};
	wire        cond_holds;
	wire [2:0]  kind;
	wire        is_cond;
	wire [1:0]  length;
	wire [3:0]  dec_cycles;
	wire [4:0]  dec_states;

	// ****************************************************************
	// Derived addresses
	// ****************************************************************
	// Unconditional opcodes count as taken
	wire        taken = ~is_cond | cond_holds;
	// Next address skips the whole instruction
	wire [15:0] next_pc = program_counter_r + {14'h0000, length};
	// Vector lands on an eight-byte boundary
	wire [15:0] rst_vector = {10'h000, opcode[5:3], 3'h0};

	// Condition evaluator on the condition field
	bfc_cond_eval u_cond (
		.condition_select_field (opcode[5:3]),
		.flags                  (flags_r),
		.cond_holds             (cond_holds)
	);

	// Opcode classification and timing table
	bfc_decode u_dec (
		.opcode  (opcode),
		.taken   (taken),
		.kind    (kind),
		.is_cond (is_cond),
		.length  (length),
		.cycles  (dec_cycles),
		.states  (dec_states)
	);

	// ****************************************************************
	// APB decode
	// ****************************************************************
	// Setup cycle, finished access, and a write that lands
	wire setup_phase = psel & ~penable;
	wire access_done = psel & penable & pready;
	wire wr_commit   = access_done & pwrite & ~pslverr;
	reg  [31:0] rd_mux;
	reg         addr_ok;

	// Read data and address check for the setup cycle
	always @* begin
		rd_mux  = 32'h00000000;
		addr_ok = 1'b1;
		case (paddr)
		`BFC_OFS_CTRL:   rd_mux = 32'h00000000;
		`BFC_OFS_INSTR:  rd_mux = {8'h00, instr_r};
		`BFC_OFS_PC:     rd_mux = {16'h0000, program_counter_r};
		`BFC_OFS_STACK:  rd_mux = {16'h0000, stack_pointer_r};
		`BFC_OFS_HL:     rd_mux = {16'h0000, hl_r};
		`BFC_OFS_FLAGS:  rd_mux = {24'h000000, flags_r};
		`BFC_OFS_STATUS: begin
			rd_mux[`BFC_ST_BUSY]    = exec_busy;
			rd_mux[`BFC_ST_DONE]    = done_r;
			rd_mux[`BFC_ST_TAKEN]   = taken_r;
			rd_mux[`BFC_ST_ILLEGAL] = illegal_r;
			rd_mux[`BFC_ST_CYC_LSB +: 4] = cycles_r;
			rd_mux[`BFC_ST_STA_LSB +: 5] = states_r;
		end
		// Unmapped offsets answer with an error and zero data
		default: addr_ok = 1'b0;
		endcase
	end

	// Zero-wait answer: ready, data and error registered in setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			// Answer in the access cycle, no wait state
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h00000000 : rd_mux;
			pslverr <= ~addr_ok;
		end else begin
			// Ready and error stand for one cycle only; read data holds
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ****************************************************************
	// Start request
	// ****************************************************************
	// Writes land only while idle; a busy unit drops them silently
	wire sw_wr_ok = wr_commit & ~exec_busy;
	// Start bit of the control word kicks one instruction
	wire start = sw_wr_ok & (paddr == `BFC_OFS_CTRL)
		& pwdata[`BFC_CTRL_START];

	// ****************************************************************
	// Software-visible registers
	// ****************************************************************

	// Instruction bytes, H/L pair and flags: software only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_r <= `BFC_RST_INSTR;
			hl_r    <= `BFC_RST_HL;
			flags_r <= `BFC_RST_FLAGS;
		end else if (sw_wr_ok) begin
			if (paddr == `BFC_OFS_INSTR)
				instr_r <= pwdata[23:0];
			if (paddr == `BFC_OFS_HL)
				hl_r <= pwdata[15:0];
			// Only software writes flags; execution never does
			if (paddr == `BFC_OFS_FLAGS)
				flags_r <= pwdata[7:0];
		end
	end

	// ****************************************************************
	// Execution sequencer
	// ****************************************************************

	// Program counter, stack pointer, memory strobes and status
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Idle with zeroed registers and quiet strobes
			state_r           <= S_IDLE;
			program_counter_r <= `BFC_RST_PC;
			stack_pointer_r   <= `BFC_RST_STACK;
			target_r          <= 16'h0000;
			return_addr_r     <= 16'h0000;
			pop_low_r         <= 8'h00;
			mem_addr          <= 16'h0000;
			mem_wdata         <= 8'h00;
			mem_wr            <= 1'b0;
			mem_rd            <= 1'b0;
			exec_busy         <= 1'b0;
			done_r            <= 1'b0;
			taken_r           <= 1'b0;
			illegal_r         <= 1'b0;
			cycles_r          <= 4'h0;
			states_r          <= 5'h00;
		end else begin
			// Strobes are one-cycle pulses unless a state raises them
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
			case (state_r)
			S_IDLE: begin
				// PC and stack pointer move only between instructions
				if (sw_wr_ok && paddr == `BFC_OFS_PC)
					program_counter_r <= pwdata[15:0];
				if (sw_wr_ok && paddr == `BFC_OFS_STACK)
					stack_pointer_r <= pwdata[15:0];
				if (start) begin
					state_r   <= S_EXEC;
					exec_busy <= 1'b1;
					done_r    <= 1'b0;
					taken_r   <= 1'b0;
					illegal_r <= 1'b0;
				end
			end
			S_EXEC: begin
				// Non-branch opcodes never count as taken
				taken_r  <= taken & (kind != `BFC_K_NONE);
				cycles_r <= dec_cycles;
				states_r <= dec_states;
				case (kind)
				`BFC_K_JUMP: begin
					// Untaken conditional jump falls through
					program_counter_r <= taken ? addr_bytes
						: next_pc;
					state_r <= S_IDLE;
				end
				`BFC_K_CALL, `BFC_K_RST: begin
					if (taken) begin
						// High byte of return address first
						return_addr_r <= next_pc;
						target_r   <= (kind == `BFC_K_RST) ?
							rst_vector : addr_bytes;
						mem_addr   <= stack_pointer_r - 16'h0001;
						mem_wdata  <= next_pc[15:8];
						mem_wr     <= 1'b1;
						state_r    <= S_PUSH_A;
					end else begin
						// No stack traffic, skip the instruction
						program_counter_r <= next_pc;
						state_r <= S_IDLE;
					end
				end
				`BFC_K_RETURN: begin
					if (taken) begin
						// Low byte first, from the top of stack
						mem_addr <= stack_pointer_r;
						mem_rd   <= 1'b1;
						state_r  <= S_POP_A;
					end else begin
						// Condition false: skip the one-byte return
						program_counter_r <= next_pc;
						state_r <= S_IDLE;
					end
				end
				`BFC_K_HL: begin
					// H fills the high half, L the low half
					program_counter_r <= hl_r;
					state_r <= S_IDLE;
				end
				default: begin
					// Not a branch opcode: flag illegal, PC and stack pointer unchanged
					illegal_r <= 1'b1;
					state_r   <= S_IDLE;
				end
				endcase
				// Single-step and untaken instructions end here
				if (kind == `BFC_K_JUMP || kind == `BFC_K_HL
					|| kind == `BFC_K_NONE || !taken) begin
					exec_busy <= 1'b0;
					done_r    <= 1'b1;
				end
			end
			S_PUSH_A: begin
				// Low byte of return address below the high byte
				mem_addr  <= stack_pointer_r - 16'h0002;
				mem_wdata <= return_addr_r[7:0];
				mem_wr    <= 1'b1;
				state_r   <= S_PUSH_B;
			end
			S_PUSH_B: begin
				// Both bytes written: commit stack pointer and jump in the same cycle
				stack_pointer_r   <= stack_pointer_r - 16'h0002;
				program_counter_r <= target_r;
				exec_busy         <= 1'b0;
				done_r            <= 1'b1;
				state_r           <= S_IDLE;
			end
			S_POP_A: begin
				// Second read for the high byte
				mem_addr <= stack_pointer_r + 16'h0001;
				mem_rd   <= 1'b1;
				state_r  <= S_POP_B;
			end
			S_POP_B: begin
				// Low byte is on the bus now; keep it
				pop_low_r <= mem_rdata;
				state_r   <= S_POP_C;
			end
			S_POP_C: begin
				// High byte arrives; join it with the saved low byte
				program_counter_r <= {mem_rdata, pop_low_r};
				stack_pointer_r   <= stack_pointer_r + 16'h0002;
				exec_busy         <= 1'b0;
				done_r            <= 1'b1;
				state_r           <= S_IDLE;
			end
			default: begin
				// Unused state code: recover to idle
				exec_busy <= 1'b0;
				state_r   <= S_IDLE;
			end
			endcase
		end
	end

endmodule // bfc_branch_unit

// [pkg/bfc_regs.vh]
// Constants for the branch flow control unit: register offsets, fields,
// reset values, opcode patterns and documented cycle/state counts.
// Assumes an 8-bit APB byte address and 32-bit data.
`ifndef BFC_REGS_VH
`define BFC_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define BFC_OFS_CTRL    8'h00
`define BFC_OFS_INSTR   8'h04
`define BFC_OFS_PC      8'h08
`define BFC_OFS_STACK   8'h0C
`define BFC_OFS_HL      8'h10
`define BFC_OFS_FLAGS   8'h14
`define BFC_OFS_STATUS  8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define BFC_CTRL_START  0
`define BFC_FLG_CARRY   0
`define BFC_FLG_PARITY  2
`define BFC_FLG_AUX     4
`define BFC_FLG_ZERO    6
`define BFC_FLG_SIGN    7
`define BFC_ST_BUSY     0
`define BFC_ST_DONE     1
`define BFC_ST_TAKEN    2
`define BFC_ST_ILLEGAL  3
`define BFC_ST_CYC_LSB  8
`define BFC_ST_STA_LSB  16

// ****************************************************************
// Reset values
// ****************************************************************
`define BFC_RST_PC      16'h0000
`define BFC_RST_STACK   16'h0000
`define BFC_RST_HL      16'h0000
`define BFC_RST_FLAGS   8'h00
`define BFC_RST_INSTR   24'h000000

// ****************************************************************
// Instruction kinds
// ****************************************************************
`define BFC_K_NONE      3'h0
`define BFC_K_JUMP      3'h1
`define BFC_K_CALL      3'h2
`define BFC_K_RST       3'h3
`define BFC_K_RETURN    3'h4
`define BFC_K_HL        3'h5

// Opcode patterns
`define BFC_OP_JUMP     8'hC3
`define BFC_OP_CALL     8'hCD
`define BFC_OP_RETURN   8'hC9
`define BFC_OP_HL       8'hE9
`define BFC_LOW_JCC     3'h2
`define BFC_LOW_CCALL   3'h4
`define BFC_LOW_RST     3'h7
`define BFC_LOW_RCC     3'h0

// ****************************************************************
// Documented machine cycles and states
// ****************************************************************
`define BFC_CYC_JUMP    4'h3
`define BFC_STA_JUMP    5'h0A
`define BFC_CYC_CALL    4'h5
`define BFC_STA_CALL    5'h11
`define BFC_CYC_CALL_NT 4'h3
`define BFC_STA_CALL_NT 5'h0B
`define BFC_CYC_RST     4'h3
`define BFC_STA_RST     5'h0B
`define BFC_CYC_RETURN  4'h3
`define BFC_STA_RETURN  5'h0A
`define BFC_CYC_RETURN_NT 4'h1
`define BFC_STA_RETURN_NT 5'h05
`define BFC_CYC_RETURN_T 4'h3
`define BFC_STA_RETURN_T 5'h0B
`define BFC_CYC_HL      4'h1
`define BFC_STA_HL      5'h05

`endif

// [hw/bfc_cond_eval.v]
// Condition test for conditional branches: picks one flag by the
// upper two bits of the condition field, compares to the lowest bit.
// Assumes the flag byte layout of the register header.
`timescale 1ns/1ps
`include "bfc_regs.vh"

module bfc_cond_eval (
	// Condition select and processor flags
	input  wire [2:0] condition_select_field,
	input  wire [7:0] flags,
	// Result
	output reg        cond_holds
);

	// ****************************************************************
	// Flag selection
	// ****************************************************************

	// Pick flag, then require it equal to the polarity bit
	always @* begin
		case (condition_select_field[2:1])
		2'b00: cond_holds = flags[`BFC_FLG_ZERO]
			== condition_select_field[0];
		2'b01: cond_holds = flags[`BFC_FLG_CARRY]
			== condition_select_field[0];
		2'b10: cond_holds = flags[`BFC_FLG_PARITY]
			== condition_select_field[0];
		default: cond_holds = flags[`BFC_FLG_SIGN]
			== condition_select_field[0];
		endcase
	end

endmodule // bfc_cond_eval

// [hw/bfc_decode.v]
// Opcode decoder for the branch group: kind, conditional marker,
// instruction length and the documented cycle and state counts.
// Assumes the taken input is valid whenever the opcode is conditional.
`timescale 1ns/1ps
`include "bfc_regs.vh"

module bfc_decode (
	// Opcode and branch decision
	input  wire [7:0] opcode,
	input  wire       taken,
	// Decode results
	output reg  [2:0] kind,
	output reg        is_cond,
	output reg  [1:0] length,
	output reg  [3:0] cycles,
	output reg  [4:0] states
);

	// ****************************************************************
	// Decode table
	// ****************************************************************

	// Classify by fixed opcodes first, then by low three bits
	always @* begin
		kind    = `BFC_K_NONE;
		is_cond = 1'b0;
		length  = 2'd1;
		cycles  = 4'h0;
		states  = 5'h00;
		if (opcode == `BFC_OP_JUMP) begin
			kind   = `BFC_K_JUMP;
			length = 2'd3;
			cycles = `BFC_CYC_JUMP;
			states = `BFC_STA_JUMP;
		end else if (opcode == `BFC_OP_CALL) begin
			kind   = `BFC_K_CALL;
			length = 2'd3;
			cycles = `BFC_CYC_CALL;
			states = `BFC_STA_CALL;
		end else if (opcode == `BFC_OP_RETURN) begin
			kind   = `BFC_K_RETURN;
			cycles = `BFC_CYC_RETURN;
			states = `BFC_STA_RETURN;
		end else if (opcode == `BFC_OP_HL) begin
			kind   = `BFC_K_HL;
			cycles = `BFC_CYC_HL;
			states = `BFC_STA_HL;
		end else if (opcode[7:6] == 2'b11) begin
			case (opcode[2:0])
			`BFC_LOW_JCC: begin
				kind    = `BFC_K_JUMP;
				is_cond = 1'b1;
				length  = 2'd3;
				cycles  = `BFC_CYC_JUMP;
				states  = `BFC_STA_JUMP;
			end
			`BFC_LOW_CCALL: begin
				kind    = `BFC_K_CALL;
				is_cond = 1'b1;
				length  = 2'd3;
				cycles  = taken ? `BFC_CYC_CALL : `BFC_CYC_CALL_NT;
				states  = taken ? `BFC_STA_CALL : `BFC_STA_CALL_NT;
			end
			`BFC_LOW_RST: begin
				kind   = `BFC_K_RST;
				cycles = `BFC_CYC_RST;
				states = `BFC_STA_RST;
			end
			`BFC_LOW_RCC: begin
				kind    = `BFC_K_RETURN;
				is_cond = 1'b1;
				cycles  = taken ? `BFC_CYC_RETURN_T : `BFC_CYC_RETURN_NT;
				states  = taken ? `BFC_STA_RETURN_T : `BFC_STA_RETURN_NT;
			end
			default: kind = `BFC_K_NONE;
			endcase
		end
	end

endmodule // bfc_decode

// [test/bfc_branch_monitor.sv]
// Port checker for the branch unit: APB answer timing, stack strobes.
// Assumes it is bound to bfc_branch_unit, one clock domain.
`timescale 1ns/1ps

module bfc_branch_monitor (
	// Clock and reset
	input wire        pclk,
	input wire        presetn,
	// APB answer
	input wire        psel,
	input wire        penable,
	input wire        pready,
	input wire        pslverr,
	// Stack port and state
	input wire [15:0] mem_addr,
	input wire        mem_wr,
	input wire        mem_rd,
	input wire        exec_busy
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ****************************************
	// Assertions
	// ****************************************
	a_ready_no_wait: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	a_push_high_low: assert property (
		$rose(mem_wr) |=> mem_wr && mem_addr == $past(mem_addr) - 16'h0001)
		else $error("second push byte not one below first");
	a_push_two_only: assert property (mem_wr ##1 mem_wr |=> !mem_wr)
		else $error("more than two push writes");
	a_pop_low_high: assert property (
		$rose(mem_rd) |=> mem_rd && mem_addr == $past(mem_addr) + 16'h0001)
		else $error("second pop byte not one above first");
	a_pop_two_only: assert property (mem_rd [*2] |=> !mem_rd)
		else $error("more than two pop reads");
	a_idle_no_stack: assert property (!exec_busy |-> !mem_wr && !mem_rd)
		else $error("stack access while idle");
	a_busy_bounded: assert property (
		$rose(exec_busy) |-> ##[1:5] !exec_busy)
		else $error("execution too long");
	a_no_rw_mix: assert property (!(mem_wr && mem_rd))
		else $error("read and write together");
endmodule // bfc_branch_monitor

bind bfc_branch_unit bfc_branch_monitor mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
	.exec_busy(exec_busy));

// [test/bfc_stack_mem.sv]
// Behavioural stack memory on the far side of the branch unit.
// Assumes read data is due in the cycle after the read strobe.
`timescale 1ns/1ps

module bfc_stack_mem (
	// Clock
	input  wire        pclk,
	// Memory port
	input  wire [15:0] mem_addr,
	input  wire [7:0]  mem_wdata,
	input  wire        mem_wr,
	input  wire        mem_rd,
	output logic [7:0] mem_rdata
);
	logic [7:0] store [0:65535];

	initial mem_rdata = 8'hA5;
	// Keep written bytes; outside a read the bus toggles, never stale
	always @(posedge pclk) begin
		if (mem_wr)
			store[mem_addr] <= mem_wdata;
		if (mem_rd)
			mem_rdata <= store[mem_addr];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule // bfc_stack_mem

// [test/tb_top.sv]
// Self-checking bench for the branch unit over APB.
// Assumes stack memory model and bound port checker.
`timescale 1ns/1ps
`include "bfc_regs.vh"

module tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire  [15:0] mem_addr;
	wire  [7:0]  mem_wdata;
	wire         mem_wr;
	wire         mem_rd;
	wire  [7:0]  mem_rdata;
	wire         exec_busy;
	logic [32:0] notes [$];
	logic [32:0] want;
	logic [7:0]  flg;
	logic [15:0] a;
	logic [15:0] p;
	logic [15:0] s;
	logic [2:0]  cc;
	logic        tk;
	logic        ill;
	integer      seed;
	int          failures;
	int          total_checks;
	int          i;

	bfc_branch_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
		.exec_busy(exec_busy));
	bfc_stack_mem mem (.pclk(pclk), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_rdata(mem_rdata));

	always #25 pclk = ~pclk;

	// Compare each read answer with the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
			want = notes.pop_front();
			total_checks++;
			if ({pslverr, prdata} !== want) begin
				failures++;
				$display("wrong value at %0t: got %h expected %h", $time,
					{pslverr, prdata}, want);
			end
		end
	end

	task automatic wrap_up;
		begin
			$display("checks %0d mismatches %0d", total_checks, failures);
			if (failures == 0 && total_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	// One APB transfer, held until ready is sampled high
	task automatic xfer(input logic wr, input logic [7:0] ad,
		input logic [31:0] d);
		int n;
		begin
			n = 0;
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= wr;
			paddr <= ad;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			do begin
				@(posedge pclk);
				n++;
			end while (pready !== 1'b1 && n < 16);
			if (n >= 16) begin
				failures++;
				wrap_up;
			end
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask

	task automatic rd(input logic [7:0] ad, input logic [32:0] e);
		begin
			notes.push_back(e);
			xfer(1'b0, ad, 32'h00000000);
		end
	endtask

	// Random operands; selected flag forced so the condition equals k[3]
	task automatic pick(input logic [3:0] k);
		logic [7:0] m;
		begin
			cc = k[2:0];
			tk = k[3];
			m = cc[2:1] == 2'h0 ? 8'h40 : cc[2:1] == 2'h1 ? 8'h01 :
				cc[2:1] == 2'h2 ? 8'h04 : 8'h80;
			a = 16'($random(seed));
			p = 16'($random(seed));
			s = 16'($random(seed));
			flg = (8'($random(seed)) & 8'hD5 & ~m) | ({8{~(tk ^ cc[0])}} & m);
		end
	endtask

	// Load state, execute one instruction, check status and registers
	task automatic run(input logic [23:0] ins, input logic [15:0] pc,
		input logic [15:0] sp, input logic [15:0] ept,
		input logic [15:0] eps, input logic t, input logic [3:0] cy,
		input logic [4:0] st);
		int n;
		begin
			n = 0;
			xfer(1'b1, `BFC_OFS_PC, {16'h0000, pc});
			xfer(1'b1, `BFC_OFS_STACK, {16'h0000, sp});
			xfer(1'b1, `BFC_OFS_FLAGS, {24'h000000, flg});
			xfer(1'b1, `BFC_OFS_INSTR, {8'h00, ins});
			xfer(1'b1, `BFC_OFS_CTRL, 32'h00000001);
			while (exec_busy !== 1'b0 && n < 16) begin
				@(posedge pclk);
				n++;
			end
			if (n >= 16) begin
				failures++;
				wrap_up;
			end
			rd(`BFC_OFS_STATUS, {12'h000, st, 4'h0, cy, 4'h0, ill, t, 2'h2});
			rd(`BFC_OFS_PC, {17'h00000, ept});
			rd(`BFC_OFS_STACK, {17'h00000, eps});
			rd(`BFC_OFS_FLAGS, {25'h0000000, flg});
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		failures = 0;
		total_checks = 0;
		ill = 1'b0;
		seed = 32'h71602EDE;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 7; i++)
			rd(8'(i * 4), 33'h000000000);
		rd(8'h1C, 33'h100000000);
		$display("test reset and map done");
		pick(4'h0);
		run({a, `BFC_OP_JUMP}, p, s, a, s, 1'b1, 4'h3, 5'h0A);
		for (i = 0; i < 16; i++) begin
			pick(4'(i));
			run({a, 2'b11, cc, 3'b010}, p, s,
				tk ? a : p + 16'h0003, s, tk, 4'h3, 5'h0A);
		end
		$display("test jumps done");
		pick(4'h0);
		run({a, `BFC_OP_CALL}, p, s, a, s - 16'h0002, 1'b1, 4'h5, 5'h11);
		run({16'h0000, `BFC_OP_RETURN}, a, s - 16'h0002,
			p + 16'h0003, s, 1'b1, 4'h3, 5'h0A);
		for (i = 0; i < 16; i++) begin
			pick(4'(i));
			run({a, 2'b11, cc, 3'b100}, p, s,
				tk ? a : p + 16'h0003, tk ? s - 16'h0002 : s, tk,
				tk ? 4'h5 : 4'h3, tk ? 5'h11 : 5'h0B);
		end
		$display("test calls done");
		for (i = 0; i < 8; i++) begin
			pick(4'h0);
			run({16'h0000, 2'b11, 3'(i), 3'b111}, p, s,
				{10'h000, 3'(i), 3'h0}, s - 16'h0002, 1'b1, 4'h3, 5'h0B);
			run({16'h0000, `BFC_OP_RETURN}, a, s - 16'h0002,
				p + 16'h0001, s, 1'b1, 4'h3, 5'h0A);
		end
		$display("test restarts done");
		for (i = 0; i < 16; i++) begin
			pick(4'(i));
			run({a, `BFC_OP_CALL}, p, s, a, s - 16'h0002, 1'b1, 4'h5, 5'h11);
			run({16'h0000, 2'b11, cc, 3'b000}, a, s - 16'h0002,
				tk ? p + 16'h0003 : a + 16'h0001, tk ? s : s - 16'h0002,
				tk, tk ? 4'h3 : 4'h1, tk ? 5'h0B : 5'h05);
		end
		$display("test returns done");
		// Non-branch opcode: illegal status bit set, PC and stack pointer unchanged
		pick(4'h0);
		ill = 1'b1;
		run({16'h0000, 8'h00}, p, s, p, s, 1'b0, 4'h0, 5'h00);
		ill = 1'b0;
		$display("test illegal opcode done");
		pick(4'h0);
		xfer(1'b1, `BFC_OFS_HL, {16'h0000, a});
		rd(`BFC_OFS_HL, {17'h00000, a});
		run({16'h0000, `BFC_OP_HL}, p, s, a, s, 1'b1, 4'h1, 5'h05);
		$display("test register jump done");
		wrap_up;
	end
endmodule // tb_top
